//--- rtl/pulse_counter.sv
// pulse input counter / speed meter top with register port and interrupt
// assumes a plain strobe register bus; nv_value is kept by an external
// non-volatile store and restored through nv_valid after power-up
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ns
`default_nettype none
module pulse_counter #(
    parameter int speed_window = pulse_count_pkg::speed_window_cycles
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pulse_in,
    input wire logic count_reset_n,
    input wire pulse_count_pkg::bus_req_type bus,
    output logic [15:0] rdata,
    output logic irq,
    input wire logic [13:0] nv_value,
    input wire logic nv_valid,
    output logic [13:0] nv_store,
    output logic nv_store_en,
    output pulse_count_pkg::show_type shown
);
    import pulse_count_pkg::*;

    initial begin
        if (speed_window < 1) begin
            $error("speed_window must be at least one");
        end
    end

    // ------------------------------------------------
    // input synchronisers
    // ------------------------------------------------
    logic [1:0] pulse_meta;
    logic [1:0] hold_meta;
    // pulse flops run through reset so the edge detector sees the pin level
    always_ff @(posedge clk) begin
        pulse_meta <= {pulse_meta[0], pulse_in};
        if (rst) begin
            hold_meta <= 2'h3;
        end else begin
            hold_meta <= {hold_meta[0], count_reset_n};
        end
    end
    wire pulse_sync = pulse_meta[1];
    wire hold_active = ~hold_meta[1];

    // ------------------------------------------------
    // registers
    // ------------------------------------------------
    config_type cfg;
    logic [9:0] prescale;
    logic [13:0] count_upper_limit;
    logic [2:0] status;
    logic [2:0] mask;
    logic [13:0] count;
    logic [13:0] speed;
    logic [13:0] speed_acc;
    logic [31:0] window;
    logic [31:0] gap;
    logic range_err;
    logic input_err;
    logic edge_seen;
    logic tick;

    function automatic logic [13:0] clip14(input logic [15:0] v, input logic [13:0] top);
        clip14 = (v[13:0] > top || v[15:14] != 2'h0) ? top : v[13:0];
    endfunction

    wire wr_config = bus.wr && bus.addr == reg_config;
    wire wr_prescale = bus.wr && bus.addr == reg_prescale;
    wire wr_limit = bus.wr && bus.addr == reg_limit;
    wire wr_mask = bus.wr && bus.addr == reg_mask;
    wire rd_status = bus.rd && bus.addr == reg_status;
    wire [15:0] prescale_clip = (bus.wdata == 16'h0000) ? 16'h0001
        : {2'h0, clip14(bus.wdata, {4'h0, prescale_max})};

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg <= '0;
            prescale <= prescale_reset[9:0];
            count_upper_limit <= limit_reset;
            mask <= 3'h0;
        end else begin
            if (wr_config) begin
                cfg <= config_type'(bus.wdata[8:0]);
            end
            if (wr_prescale) begin
                prescale <= prescale_clip[9:0];
            end
            if (wr_limit) begin
                count_upper_limit <= clip14(bus.wdata, count_top);
            end
            if (wr_mask) begin
                mask <= bus.wdata[2:0];
            end
        end
    end

    // ------------------------------------------------
    // prescaler
    // ------------------------------------------------
    pulse_prescaler #(
        .div_width(10)
    ) prescaler (
        .clk(clk),
        .rst(rst),
        .pulse_sync(pulse_sync),
        .edge_falling(cfg.edge_falling),
        .factor(prescale),
        .clear(hold_active),
        .edge_seen(edge_seen),
        .tick(tick)
    );

    // ------------------------------------------------
    // counter
    // ------------------------------------------------
    wire counting_down = cfg.mode == count_down_function;
    wire counting = cfg.mode != speed_measure_function;
    wire [13:0] start_value = counting_down ? count_upper_limit : 14'h0000;
    wire at_top = count == measure_top;
    wire at_bottom = count == 14'h0000;
    wire above = count > count_upper_limit;
    logic restored;
    logic mode_seen;
    logic [1:0] last_mode;

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= 14'h0000;
            restored <= 1'b0;
            last_mode <= 2'h0;
        end else begin
            last_mode <= cfg.mode;
            if (!restored) begin
                if (nv_valid) begin
                    count <= nv_value;
                    restored <= 1'b1;
                end
            end else if (hold_active || last_mode != cfg.mode) begin
                count <= start_value;
            end else if (tick && counting) begin
                if (!counting_down) begin
                    if (!at_top && !(cfg.range_limit_policy != limit_off && above)) begin
                        count <= count + 14'h0001;
                    end
                end else if (!at_bottom) begin
                    count <= count - 14'h0001;
                end
            end
        end
    end
    assign mode_seen = restored;
    assign nv_store = count;
    assign nv_store_en = mode_seen && tick && counting;

    // ------------------------------------------------
    // speed measurement
    // ------------------------------------------------
    // speed uses prescaled ticks
    always_ff @(posedge clk) begin
        if (rst) begin
            window <= 32'h0;
            speed_acc <= 14'h0000;
            speed <= 14'h0000;
        end else if (window >= 32'(speed_window - 1)) begin
            window <= 32'h0;
            speed <= speed_acc;
            speed_acc <= tick ? 14'h0001 : 14'h0000;
        end else begin
            window <= window + 32'h1;
            if (tick && speed_acc != measure_top) begin
                speed_acc <= speed_acc + 14'h0001;
            end
        end
    end

    // ------------------------------------------------
    // input frequency check
    // ------------------------------------------------
    // above 10 kHz
    always_ff @(posedge clk) begin
        if (rst) begin
            gap <= 32'hffffffff;
            input_err <= 1'b0;
        end else if (edge_seen) begin
            input_err <= gap < 32'(min_period_cycles - 1);
            gap <= 32'h0;
        end else if (gap != 32'hffffffff) begin
            gap <= gap + 32'h1;
        end
    end

    // ------------------------------------------------
    // shown value
    // ------------------------------------------------
    wire [13:0] raw = counting ? count : speed;
    wire out_of_range = raw > count_upper_limit;
    assign range_err = counting && cfg.range_limit_policy == limit_flag_error && out_of_range;
    wire [13:0] clamped = (counting && cfg.range_limit_policy == limit_clamp && out_of_range)
        ? count_upper_limit : raw;
    always_ff @(posedge clk) begin
        if (rst) begin
            shown <= '0;
        end else begin
            shown.value <= clip14({2'h0, clamped}, measure_top);
            shown.point <= cfg.point_position;
            shown.error <= range_err || input_err;
        end
    end

    // ------------------------------------------------
    // status, interrupt, read port
    // ------------------------------------------------
    wire [2:0] events = {input_err, range_err, tick & counting};
    always_ff @(posedge clk) begin
        if (rst) begin
            status <= 3'h0;
        end else begin
            status <= (rd_status ? 3'h0 : status) | events;
        end
    end
    assign irq = |(status & mask);

    wire [15:0] rd_mux = (bus.addr == reg_config) ? {7'h00, cfg}
        : (bus.addr == reg_prescale) ? {6'h00, prescale}
        : (bus.addr == reg_limit) ? {2'h0, count_upper_limit}
        : (bus.addr == reg_value) ? {2'h0, raw}
        : (bus.addr == reg_status) ? {13'h0000, status}
        : (bus.addr == reg_mask) ? {13'h0000, mask}
        : 16'h0000;
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= bus.rd ? rd_mux : 16'h0000;
        end
    end

    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    sequence hold_seen;
        restored && hold_active;
    endsequence
    AST_HOLD_START: assert property (@(posedge clk) disable iff (rst)
        hold_seen ##1 hold_active |-> count == start_value)
        else $error("count not held at start");
    AST_UP_STEP: assert property (@(posedge clk) disable iff (rst)
        (restored && !hold_active && tick && cfg.mode == count_up_function
         && $stable(cfg.mode) && cfg.range_limit_policy == limit_off && !at_top)
        |=> count == $past(count) + 14'h0001)
        else $error("up count missed step");
    AST_DOWN_STEP: assert property (@(posedge clk) disable iff (rst)
        (restored && !hold_active && tick && counting_down && $stable(cfg.mode) && !at_bottom)
        |=> count == $past(count) - 14'h0001)
        else $error("down count missed step");
    AST_FLOOR: assert property (@(posedge clk) disable iff (rst)
        (restored && counting_down && at_bottom && !hold_active && $stable(cfg.mode))
        |=> at_bottom)
        else $error("down count went below zero");
    AST_RESTORE: assert property (@(posedge clk) disable iff (rst)
        (!restored && nv_valid) |=> count == $past(nv_value))
        else $error("stored value not restored");
    AST_ERR_FLAG: assert property (@(posedge clk) disable iff (rst)
        range_err |=> shown.error)
        else $error("range error not shown");
    AST_CLAMP: assert property (@(posedge clk) disable iff (rst)
        (counting && cfg.range_limit_policy == limit_clamp)
        |=> shown.value <= $past(count_upper_limit))
        else $error("clamp exceeded limit");
    AST_POINT: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> shown.point == $past(cfg.point_position))
        else $error("point not followed");
    AST_EDGE: assert property (@(posedge clk) disable iff (rst)
        edge_seen |-> (cfg.edge_falling ? !pulse_sync : pulse_sync))
        else $error("wrong edge taken");
    AST_FAST: assert property (@(posedge clk) disable iff (rst)
        (edge_seen && gap < 32'(min_period_cycles - 1)) |=> input_err)
        else $error("fast input not flagged");
endmodule
`default_nettype wire

//--- rtl/pulse_count_pkg.sv
// pulse counter package: config carrier, limits, register map, timing
// assumes a 125 MHz system clock
package pulse_count_pkg;
    localparam int clk_hz = 125000000;
    localparam int max_input_hz = 10000;
    // shortest legal input period in cycles
    localparam int min_period_cycles = clk_hz / max_input_hz;
    localparam int speed_window_hz = 1;
    localparam int speed_window_cycles = clk_hz / speed_window_hz;
    localparam logic [13:0] count_top = 14'h270f;
    localparam logic [13:0] measure_top = 14'h3fff;
    localparam logic [9:0] prescale_max = 10'h3e8;
    localparam logic [13:0] prescale_reset = 14'h0001;
    localparam logic [13:0] limit_reset = 14'h270f;
    localparam logic [1:0] point_reset = 2'h0;
    // register offsets
    localparam logic [3:0] reg_config = 4'h0;
    localparam logic [3:0] reg_prescale = 4'h1;
    localparam logic [3:0] reg_limit = 4'h2;
    localparam logic [3:0] reg_value = 4'h3;
    localparam logic [3:0] reg_status = 4'h4;
    localparam logic [3:0] reg_mask = 4'h5;
    // config field positions
    localparam int cfg_mode_lsb = 0;
    localparam int cfg_policy_lsb = 2;
    localparam int cfg_point_lsb = 4;
    localparam int cfg_edge_bit = 6;
    localparam int cfg_kind_lsb = 7;
    // status bits
    localparam int st_count = 0;
    localparam int st_range = 1;
    localparam int st_input = 2;
    typedef enum logic [1:0] {
        speed_measure_function = 2'h0,
        count_up_function = 2'h1,
        count_down_function = 2'h2
    } mode_type;
    typedef enum logic [1:0] {
        limit_off = 2'h0,
        limit_flag_error = 2'h1,
        limit_clamp = 2'h2
    } policy_type;
    typedef enum logic [1:0] {
        kind_logic = 2'h0,
        kind_npn = 2'h1,
        kind_pnp = 2'h2
    } kind_type;
    typedef struct packed {
        kind_type input_kind_select;
        logic edge_falling;
        logic [1:0] point_position;
        policy_type range_limit_policy;
        mode_type mode;
    } config_type;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;
    typedef struct packed {
        logic error;
        logic [1:0] point;
        logic [13:0] value;
    } show_type;
endpackage

//--- rtl/pulse_prescaler.sv
// edge select and divide-by-n prescaler for a synchronised pulse input
// assumes the input already passed a two-flop synchroniser
`timescale 1ns/1ns
`default_nettype none
module pulse_prescaler #(
    parameter int div_width = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pulse_sync,
    input wire logic edge_falling,
    input wire logic [div_width-1:0] factor,
    input wire logic clear,
    output logic edge_seen,
    output logic tick
);
    import pulse_count_pkg::*;
    logic prev;
    logic [div_width-1:0] seen;
    wire rise = pulse_sync & ~prev;
    wire fall = ~pulse_sync & prev;
    assign edge_seen = edge_falling ? fall : rise;
    wire last = (seen + 1'b1 >= factor);
    always_ff @(posedge clk) begin
        if (rst) begin
            // track the pin so no false edge follows reset
            prev <= pulse_sync;
            seen <= '0;
            tick <= 1'b0;
        end else begin
            prev <= pulse_sync;
            tick <= edge_seen & last & ~clear;
            if (clear) begin
                seen <= '0;
            end else if (edge_seen) begin
                seen <= last ? '0 : seen + 1'b1;
            end
        end
    end
    initial begin
        if (div_width < 10) begin
            $error("div_width too small for factor 1000");
        end
    end
    AST_PRESCALE_ONE: assert property (@(posedge clk) disable iff (rst)
        (factor == 1 && edge_seen && !clear) |=> tick)
        else $error("factor one did not pass pulse");
endmodule
`default_nettype wire

//--- verif/pulse_source.sv
// pulse transmitter model: bursts of clean pulses on one line
// assumes the bench clock; the line rests at idle_high between bursts
`timescale 1ns/1ns
`default_nettype none
module pulse_source (
    input wire logic clk,
    input wire logic rst,
    input wire logic fire,
    input wire logic idle_high,
    input wire logic [7:0] count,
    input wire logic [15:0] half,
    output logic line,
    output logic busy
);
    logic [7:0] left;
    logic [15:0] timer;
    logic phase;
    // ------------------------------------------------------------
    // burst generator
    // ------------------------------------------------------------
    // logic-level bounce-free edges
    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
            phase <= 1'b0;
            left <= 8'h00;
            timer <= 16'h0000;
        end else if (fire) begin
            busy <= 1'b1;
            phase <= 1'b1;
            left <= count;
            timer <= half;
        end else if (busy) begin
            if (timer > 16'h0001) begin
                timer <= timer - 16'h0001;
            end else begin
                timer <= half;
                phase <= ~phase;
                if (phase) begin
                    left <= left - 8'h01;
                    busy <= (left != 8'h01);
                end
            end
        end
    end
    assign line = idle_high ^ phase;
endmodule
`default_nettype wire

//--- verif/pulse_prescale_updown_counter_bench.sv
// self-checking bench for the pulse counter
// assumes pulse_count_pkg and the transmitter model pulse_source
`timescale 1ns/1ns
`default_nettype none
module pulse_prescale_updown_counter_bench;
    import pulse_count_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic count_reset_n = 1'b1;
    bus_req_type bus = '0;
    logic [15:0] rdata;
    logic irq;
    logic [13:0] nv_value = 14'h0000;
    logic nv_valid = 1'b1;
    logic [13:0] nv_store;
    logic nv_store_en;
    show_type shown;
    logic fire = 1'b0;
    logic idle_high = 1'b0;
    logic [15:0] half = 16'h000a;
    logic [7:0] npulse = 8'h01;
    logic line;
    logic busy;
    logic rd_seen = 1'b0;
    logic [15:0] exp_q[$];
    logic [15:0] msk_q[$];
    logic [15:0] e;
    logic [15:0] m;
    int err_total = 0;
    int samples_checked = 0;
    int store_hits = 0;
    int n;
    int p;
    always #4 clk = ~clk;
    pulse_counter #(.speed_window(1000)) uut (
        .clk(clk), .rst(rst), .pulse_in(line), .count_reset_n(count_reset_n),
        .bus(bus), .rdata(rdata), .irq(irq), .nv_value(nv_value), .nv_valid(nv_valid),
        .nv_store(nv_store), .nv_store_en(nv_store_en), .shown(shown)
    );
    pulse_source partner (
        .clk(clk), .rst(rst), .fire(fire), .idle_high(idle_high), .count(npulse),
        .half(half), .line(line), .busy(busy)
    );
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] ex, input logic [15:0] got);
        samples_checked++;
        if (got !== ex) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, ex, got);
        end
    endtask
    task automatic summarize();
        if (err_total == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus <= {a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] ex, input logic [15:0] mk);
        exp_q.push_back(ex);
        msk_q.push_back(mk);
        bus <= {a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
    endtask
    task automatic pulses(input int cnt, input int h);
        int k;
        k = 0;
        npulse <= cnt[7:0];
        half <= h[15:0];
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (2) @(posedge clk);
        while (busy === 1'b1 && k < 60000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 60000) err_total++;
        repeat (8) @(posedge clk);
    endtask
    task automatic level(input logic v);
        idle_high <= v;
        repeat (8) @(posedge clk);
    endtask
    task automatic hold();
        count_reset_n <= 1'b0;
        repeat (8) @(posedge clk);
        count_reset_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    function automatic logic [15:0] cfg(mode_type md, policy_type po, logic [1:0] pt, logic ef);
        return {7'h00, kind_logic, ef, pt, po, md};
    endfunction
    // ------------------------------------------------------------
    // read data monitor
    // ------------------------------------------------------------
    always @(posedge clk) begin
        rd_seen <= bus.rd;
        if (rd_seen) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            check("rdata", e, rdata & m);
        end
    end
    always @(posedge clk) begin
        if (rst) store_hits <= 0;
        else if (nv_store_en === 1'b1) store_hits <= store_hits + 1;
    end
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        summarize();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h22ce8a2d));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(reg_prescale, 16'h0001, 16'hffff);
        rd(reg_limit, 16'h270f, 16'hffff);
        rd(4'hf, 16'h0000, 16'hffff);
        wr(reg_prescale, 16'h0000);
        rd(reg_prescale, 16'h0001, 16'hffff);
        wr(reg_prescale, 16'h07d0);
        rd(reg_prescale, 16'h03e8, 16'hffff);
        wr(reg_limit, 16'h2ee0);
        rd(reg_limit, 16'h270f, 16'hffff);
        wr(reg_prescale, 16'h0001);
        wr(reg_config, cfg(count_up_function, limit_off, 2'h0, 1'b0));
        hold();
        level(1'b1);
        rd(reg_value, 16'h0001, 16'hffff);
        level(1'b0);
        rd(reg_value, 16'h0001, 16'hffff);
        wr(reg_config, cfg(count_up_function, limit_off, 2'h0, 1'b1));
        hold();
        level(1'b1);
        rd(reg_value, 16'h0000, 16'hffff);
        level(1'b0);
        rd(reg_value, 16'h0001, 16'hffff);
        p = $urandom_range(4, 1);
        n = $urandom_range(12, 5);
        wr(reg_prescale, p[15:0]);
        hold();
        pulses(n, 10);
        rd(reg_value, 16'(n / p), 16'hffff);
        wr(reg_prescale, 16'h0001);
        wr(reg_limit, 16'h000a);
        wr(reg_config, cfg(count_down_function, limit_off, 2'h0, 1'b0));
        rd(reg_value, 16'h000a, 16'hffff);
        pulses(3, 10);
        rd(reg_value, 16'h0007, 16'hffff);
        count_reset_n <= 1'b0;
        pulses(4, 10);
        rd(reg_value, 16'h000a, 16'hffff);
        count_reset_n <= 1'b1;
        pulses(2, 10);
        rd(reg_value, 16'h0008, 16'hffff);
        wr(reg_mask, 16'h0001);
        rd(reg_status, 16'h0000, 16'h0000);
        check("irq idle", 16'h0000, {15'h0000, irq});
        pulses(1, 10);
        check("irq set", 16'h0001, {15'h0000, irq});
        rd(reg_status, 16'h0005, 16'h0005);
        check("irq cleared", 16'h0000, {15'h0000, irq});
        wr(reg_mask, 16'h0000);
        pulses(1, 10);
        check("irq masked", 16'h0000, {15'h0000, irq});
        wr(reg_config, cfg(speed_measure_function, limit_off, 2'h0, 1'b0));
        pulses(120, 10);
        samples_checked++;
        if ((shown.value >= 14'd48 && shown.value <= 14'd52) !== 1'b1) begin
            err_total++;
            $display("MISMATCH speed expected 50 seen %0d", shown.value);
        end
        rst <= 1'b1;
        nv_valid <= 1'b0;
        nv_value <= 14'd37;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wr(reg_config, cfg(count_up_function, limit_off, 2'h0, 1'b0));
        pulses(1, 10);
        nv_valid <= 1'b1;
        repeat (4) @(posedge clk);
        rd(reg_value, 16'h0025, 16'hffff);
        pulses(1, 10);
        rd(reg_value, 16'h0026, 16'hffff);
        check("nv_store", 16'h0026, {2'b00, nv_store});
        check("nv_store_en", 16'h0001, store_hits[15:0]);
        wr(reg_limit, 16'h0001);
        wr(reg_config, cfg(count_up_function, limit_flag_error, 2'h0, 1'b0));
        hold();
        repeat (12500) @(posedge clk);
        pulses(1, 12600);
        check("error in range", 16'h0000, {15'h0000, shown.error});
        pulses(1, 12600);
        check("error above", 16'h0001, {15'h0000, shown.error});
        wr(reg_config, cfg(count_up_function, limit_clamp, 2'h0, 1'b0));
        @(posedge clk);
        check("clamp value", 16'h0001, {2'b00, shown.value});
        wr(reg_config, cfg(count_up_function, limit_off, 2'h2, 1'b0));
        @(posedge clk);
        check("off value", 16'h0002, {2'b00, shown.value});
        check("point", 16'h0002, {14'h0000, shown.point});
        repeat (3) @(posedge clk);
        summarize();
    end
endmodule
`default_nettype wire
